// ---- logic/pcpt_capture_top.v ----
// Top of the capture precondition block: register port, input select, ns timebase
`timescale 1ns/1ps
`include "pcpt_consts.vh"
module pcpt_capture_top #(
   parameter N_GEN = 7,
   parameter N_DIFF = 3,
   parameter TIME_W = 32
) (
   input wire clk,
   input wire rst,
   input wire [`PCPT_ADDR_W-1:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [`PCPT_DATA_W-1:0] reg_wdata,
   output reg [`PCPT_DATA_W-1:0] reg_rdata,
   output reg reg_ack,
   output reg reg_err,
   input wire [N_GEN-1:0] gen_in,
   input wire [N_DIFF-1:0] diff_in,
   input wire primary_index,
   input wire periodic_sync_tick,
   input wire chan0_capture_enable,
   input wire chan0_capture_kind_select,
   input wire [7:0] chan0_precondition_edge_select,
   input wire chan0_precondition_use,
   input wire chan0_trigger_event,
   output wire chan0_capture_strobe,
   output wire [7:0] chan0_precondition_source,
   input wire chan1_capture_enable,
   input wire chan1_capture_kind_select,
   input wire [7:0] chan1_precondition_edge_select,
   input wire chan1_precondition_use,
   input wire chan1_trigger_event,
   output wire chan1_capture_strobe,
   output wire [7:0] chan1_precondition_source,
   output wire sync_lost
);

   localparam [15:0] SYNC_LOST_LIM = `PCPT_SYNC_LOST_CYC;
   localparam [TIME_W-1:0] NS_STEP = `PCPT_CLK_PERIOD_NS;
   localparam [TIME_W-1:0] NS_MAX = {TIME_W{1'b1}};

   reg [TIME_W-1:0] ns_q;
   reg [TIME_W-1:0] ns_d;
   reg [15:0] gap_q;
   reg lost_q;

   reg [7:0] src0_q;
   reg [7:0] src1_q;

   wire [1:0] en_v;
   wire [1:0] kind_v;
   wire [1:0] use_v;
   wire [1:0] trig_v;
   wire [15:0] edge_v;
   wire [15:0] src_v;
   wire [1:0] strobe_v;
   wire [1:0] flag_v;
   wire [2*TIME_W-1:0] time_v;
   wire [1:0] precond_v;

   wire [15:0] sel_in;

   reg [`PCPT_DATA_W-1:0] rdata_d;
   reg hit;
   reg bad_wr;

   // Nanosecond timebase since the latest sync tick; it saturates rather than
   // wraps so that a missing tick cannot yield a small, plausible-looking time
   always @* begin
      if (periodic_sync_tick) begin
         ns_d = {TIME_W{1'b0}};
      end else if (ns_q > NS_MAX - NS_STEP) begin
         ns_d = NS_MAX;
      end else begin
         ns_d = ns_q + NS_STEP;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         ns_q <= {TIME_W{1'b0}};
         gap_q <= 16'h0000;
         lost_q <= 1'b0;
      end else begin
         ns_q <= ns_d;
         if (periodic_sync_tick) begin
            gap_q <= 16'h0000;
            lost_q <= 1'b0;
         end else if (gap_q < SYNC_LOST_LIM) begin
            gap_q <= gap_q + 16'h0001;
         end else begin
            lost_q <= 1'b1;
         end
      end
   end

   assign sync_lost = lost_q;

   // Input map shared by both channels; code 11 is accepted but has no source
   assign sel_in[N_GEN-1:0] = gen_in;
   assign sel_in[N_GEN+N_DIFF-1:N_GEN] = diff_in;
   assign sel_in[N_GEN+N_DIFF] = primary_index;
   assign sel_in[15:N_GEN+N_DIFF+1] = {(15-N_GEN-N_DIFF){1'b0}};

   assign en_v = {chan1_capture_enable, chan0_capture_enable};
   assign kind_v = {chan1_capture_kind_select, chan0_capture_kind_select};
   assign use_v = {chan1_precondition_use, chan0_precondition_use};
   assign trig_v = {chan1_trigger_event, chan0_trigger_event};
   assign edge_v = {chan1_precondition_edge_select, chan0_precondition_edge_select};
   assign src_v = {src1_q, src0_q};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         wire [7:0] src;
         assign src = src_v[8*ch +: 8];
         assign precond_v[ch] = (src <= `PCPT_SRC_PRIMARY_INDEX) ?
                                sel_in[src[3:0]] : 1'b0;

         pcpt_chan #(
            .TIME_W(TIME_W)
         ) u_chan (
            .clk(clk),
            .rst(rst),
            .precond_in(precond_v[ch]),
            .edge_select(edge_v[8*ch +: 8]),
            .precondition_use(use_v[ch]),
            .capture_enable(en_v[ch]),
            .time_kind(kind_v[ch]),
            .trigger_event(trig_v[ch]),
            .ns_now(ns_q),
            .capture_strobe(strobe_v[ch]),
            .captured_flag(flag_v[ch]),
            .captured_time(time_v[TIME_W*ch +: TIME_W])
         );
      end
   endgenerate

   assign chan0_capture_strobe = strobe_v[0];
   assign chan1_capture_strobe = strobe_v[1];
   assign chan0_precondition_source = src0_q;
   assign chan1_precondition_source = src1_q;

   // Address decode and read data; time registers are one 32-bit word each
   always @* begin
      rdata_d = {`PCPT_DATA_W{1'b0}};
      hit = 1'b1;
      case (reg_addr)
         `PCPT_ADDR_C0_SRC: begin
            rdata_d[7:0] = src0_q;
         end
         `PCPT_ADDR_C0_FLAG: begin
            rdata_d[0] = flag_v[0];
         end
         `PCPT_ADDR_C0_TIME: begin
            rdata_d = time_v[TIME_W-1:0];
         end
         `PCPT_ADDR_C1_SRC: begin
            rdata_d[7:0] = src1_q;
         end
         `PCPT_ADDR_C1_FLAG: begin
            rdata_d[0] = flag_v[1];
         end
         `PCPT_ADDR_C1_TIME: begin
            rdata_d = time_v[2*TIME_W-1:TIME_W];
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // A write is refused when it targets a read-only or unmapped address or
   // carries a selector code outside 0..11; the old value then stays
   always @* begin
      bad_wr = 1'b1;
      if ((reg_addr == `PCPT_ADDR_C0_SRC || reg_addr == `PCPT_ADDR_C1_SRC) &&
          reg_wdata <= {24'h000000, `PCPT_SRC_MAX}) begin
         bad_wr = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         src0_q <= `PCPT_SRC_RESET;
         src1_q <= `PCPT_SRC_RESET;
         reg_rdata <= {`PCPT_DATA_W{1'b0}};
         reg_ack <= 1'b0;
         reg_err <= 1'b0;
      end else begin
         reg_ack <= reg_wr | reg_rd;
         reg_err <= 1'b0;
         if (reg_wr) begin
            reg_err <= bad_wr;
            if (!bad_wr && reg_addr == `PCPT_ADDR_C0_SRC) begin
               src0_q <= reg_wdata[7:0];
            end
            if (!bad_wr && reg_addr == `PCPT_ADDR_C1_SRC) begin
               src1_q <= reg_wdata[7:0];
            end
         end else if (reg_rd) begin
            reg_rdata <= rdata_d;
            reg_err <= ~hit;
         end
      end
   end

endmodule

// ---- logic/pcpt_chan.v ----
// One capture channel: precondition edge, arming, captured flag and time latch
`timescale 1ns/1ps
`include "pcpt_consts.vh"
module pcpt_chan #(
   parameter TIME_W = 32
) (
   input wire clk,
   input wire rst,
   input wire precond_in,
   input wire [7:0] edge_select,
   input wire precondition_use,
   input wire capture_enable,
   input wire time_kind,
   input wire trigger_event,
   input wire [TIME_W-1:0] ns_now,
   output wire capture_strobe,
   output wire captured_flag,
   output wire [TIME_W-1:0] captured_time
);

   reg pin_q;
   reg en_q;
   reg seen_q;
   reg seen_d;
   reg flag_q;
   reg flag_d;
   reg [TIME_W-1:0] time_q;
   wire en_rise;
   wire rise;
   wire fall;
   wire precond_edge;
   wire armed;
   wire qualified;
   wire fire;

   assign en_rise = capture_enable & ~en_q;
   assign rise = precond_in & ~pin_q;
   assign fall = ~precond_in & pin_q;
   // Reserved edge code 0 and unknown codes never qualify
   assign precond_edge = (edge_select == `PCPT_EDGE_RISING && rise) ||
                         (edge_select == `PCPT_EDGE_FALLING && fall) ||
                         (edge_select == `PCPT_EDGE_BOTH && (rise | fall));
   // A fresh enable rearms even if the previous run left the flag set
   assign armed = capture_enable & (en_rise | ~flag_q);
   assign qualified = ~precondition_use | seen_q | precond_edge;
   assign fire = armed & trigger_event & qualified;

   always @* begin
      seen_d = seen_q;
      if (!capture_enable || en_rise || fire) begin
         seen_d = 1'b0;
      end
      if (capture_enable && precond_edge && !fire) begin
         seen_d = 1'b1;
      end
   end

   always @* begin
      flag_d = flag_q;
      if (fire) begin
         flag_d = 1'b1;
      end else if (!capture_enable || en_rise) begin
         flag_d = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         // Follow the pin in reset so an input idling high gives no false edge
         pin_q <= precond_in;
         en_q <= 1'b0;
         seen_q <= 1'b0;
         flag_q <= 1'b0;
         time_q <= {TIME_W{1'b0}};
      end else begin
         pin_q <= precond_in;
         en_q <= capture_enable;
         seen_q <= seen_d;
         flag_q <= flag_d;
         if (fire && time_kind) begin
            time_q <= ns_now;
         end
      end
   end

   assign capture_strobe = fire;
   assign captured_flag = flag_q;
   assign captured_time = time_q;

endmodule

// ---- logic/pcpt_consts.vh ----
// Constants for the two-channel capture precondition, flag and time block
//
// Overview of operation
// - Each channel has an 8-bit precondition selector taking 0 to 11, reset 0.
// - Selector 0-6 general inputs 1-7, 7-9 differential 1-3, 10 primary index.
// - Enabling capture clears the channel's captured flag until the next capture.
// - Captured flag is read-only: 1 after a capture, 0 otherwise or disabled.
// - In time capture the event time is kept as read-only unsigned 32-bit ns.
// - Captured time counts from the latest periodic sync tick, every 62.5 us.
// - Each of the two channels reports its own captured flag.
// - Precondition edge select: 1 rising, 2 falling, 3 both, 0 reserved.
`ifndef PCPT_CONSTS_VH
`define PCPT_CONSTS_VH

`define PCPT_ADDR_W 8
`define PCPT_DATA_W 32

`define PCPT_ADDR_C0_SRC 8'h48
`define PCPT_ADDR_C0_FLAG 8'h4a
`define PCPT_ADDR_C0_TIME 8'h4c
`define PCPT_ADDR_C1_SRC 8'h62
`define PCPT_ADDR_C1_FLAG 8'h64
`define PCPT_ADDR_C1_TIME 8'h66

`define PCPT_SRC_RESET 8'h00
`define PCPT_SRC_MAX 8'h0b
`define PCPT_SRC_GEN_LAST 8'h06
`define PCPT_SRC_DIFF_FIRST 8'h07
`define PCPT_SRC_DIFF_LAST 8'h09
`define PCPT_SRC_PRIMARY_INDEX 8'h0a

`define PCPT_EDGE_RISING 8'h01
`define PCPT_EDGE_FALLING 8'h02
`define PCPT_EDGE_BOTH 8'h03

`define PCPT_CLK_PERIOD_NS 50
// Sync tick every 62.5 us, that is 1250 cycles of the 50 ns clock; counts stay integer
`define PCPT_SYNC_PERIOD_CYC 16'h04e2
`define PCPT_SYNC_LOST_CYC 16'h09c4

`endif

// ---- tb/pcpt_capture_chk.sv ----
// Port assertions for the capture block
`timescale 1ns/1ps
module pcpt_capture_chk (
   input logic clk,
   input logic rst,
   input logic [7:0] reg_addr,
   input logic reg_wr,
   input logic reg_rd,
   input logic [31:0] reg_wdata,
   input logic reg_ack,
   input logic reg_err,
   input logic chan0_capture_enable,
   input logic chan0_trigger_event,
   input logic chan0_capture_strobe,
   input logic [7:0] chan0_precondition_source,
   input logic chan1_capture_enable,
   input logic chan1_trigger_event,
   input logic chan1_capture_strobe,
   input logic [7:0] chan1_precondition_source
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_src_wr;
      reg_wr && reg_addr == 8'h48 && reg_wdata <= 32'hb;
   endsequence
   // A strobe in the cycle right after a strobe is only legal with a fresh enable rise
   sequence s_shot;
      chan0_capture_strobe ##1 !$rose(chan0_capture_enable);
   endsequence
   ack_after_req_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
      else $error("ack missing");
   src_write_a: assert property (s_src_wr |=>
      {24'h0, chan0_precondition_source} == $past(reg_wdata)) else $error("selector not written");
   src_range_a: assert property (chan0_precondition_source <= 8'hb &&
      chan1_precondition_source <= 8'hb) else $error("selector out of range");
   src_reset_a: assert property ($fell(rst) |->
      chan0_precondition_source == 8'h0 && chan1_precondition_source == 8'h0)
      else $error("selector not reset");
   ro_write_a: assert property (reg_wr && reg_addr inside {8'h4a, 8'h4c, 8'h64, 8'h66}
      |=> reg_err) else $error("read-only write accepted");
   strobe_cause_a: assert property (chan0_capture_strobe |->
      chan0_capture_enable && chan0_trigger_event) else $error("strobe without cause");
   single_shot_a: assert property (s_shot |-> !chan0_capture_strobe)
      else $error("second capture without re-arm");
   strobe_chan1_a: assert property (chan1_capture_strobe |->
      chan1_capture_enable && chan1_trigger_event) else $error("chan1 strobe without cause");
endmodule

// ---- tb/pcpt_capture_top_tb.sv ----
// Self-checking bench for the capture precondition block
`timescale 1ns/1ps
module pcpt_capture_top_tb;
   typedef struct {logic w; logic [7:0] a; logic [31:0] v; logic e;} pcpt_row_t;
   logic clk, rst, reg_wr, reg_rd, reg_ack, reg_err, tick, en0, en1, use0, tr0, tr1, st0, st1, e;
   logic kind0, lost;
   logic [7:0] reg_addr, es0, src0, src1;
   logic [10:0] io;
   logic [31:0] reg_wdata, reg_rdata, q;
   int fails = 0;
   int n_compared = 0;
   pcpt_row_t rows [10] = '{'{1'b0, 8'h48, 32'h0, 1'b0}, '{1'b0, 8'h4a, 32'h0, 1'b0},
      '{1'b1, 8'h48, 32'h5, 1'b0}, '{1'b1, 8'h62, 32'hb, 1'b0}, '{1'b0, 8'h48, 32'h5, 1'b0},
      '{1'b0, 8'h62, 32'hb, 1'b0}, '{1'b1, 8'h48, 32'hc, 1'b1}, '{1'b1, 8'h48, 32'h105, 1'b1},
      '{1'b1, 8'h4c, 32'h1, 1'b1}, '{1'b0, 8'h50, 32'h0, 1'b1}};
   pcpt_capture_top i_pcpt_capture_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_err(reg_err), .gen_in(io[6:0]), .diff_in(io[9:7]),
      .primary_index(io[10]), .periodic_sync_tick(tick), .chan0_capture_enable(en0),
      .chan0_capture_kind_select(kind0), .chan0_precondition_edge_select(es0),
      .chan0_precondition_use(use0), .chan0_trigger_event(tr0), .chan0_capture_strobe(st0),
      .chan0_precondition_source(src0), .chan1_capture_enable(en1),
      .chan1_capture_kind_select(1'b1), .chan1_precondition_edge_select(8'h01),
      .chan1_precondition_use(1'b0), .chan1_trigger_event(tr1), .chan1_capture_strobe(st1),
      .chan1_precondition_source(src1), .sync_lost(lost));
   pcpt_host_model i_pcpt_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_err(reg_err));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic ok;
      i_pcpt_host_model.access(w, a, d, q, e, ok);
      chk("ack", ok, 32'h1);
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #400000;
      fails++;
      stop_test();
   end
   initial begin
      {rst, tick, en0, en1, use0, tr0, tr1, kind0, io, es0} = {8'h81, 11'h0, 8'h01};
      step(10);
      rst = 1'b0;
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].a, rows[i].v);
         if (!rows[i].w) chk("rdata", q, rows[i].v);
         chk("err", e, rows[i].e);
      end
      $display("register rows done");
      // Other inputs toggle with the trigger, so a wrong mapping cannot hide
      use0 = 1'b1;
      for (int i = 0; i < 11; i++) begin
         acc(1'b1, 8'h48, 32'(i));
         en0 = 1'b1;
         step(1);
         tr0 = 1'b1;
         io = ~(11'h1 << i);
         #1 chk("other input", st0, 32'h0);
         step(1);
         tr0 = 1'b0;
         io = 11'h7ff;
         step(1);
         tr0 = 1'b1;
         #1 chk("selected input", st0, 32'h1);
         step(1);
         {tr0, en0, io} = 13'h0;
      end
      $display("input select done");
      acc(1'b1, 8'h48, 32'h0);
      for (int m = 0; m < 4; m++) begin
         es0 = 8'(m);
         io = 11'h1;
         step(1);
         en0 = 1'b1;
         step(1);
         io = 11'h0;
         step(1);
         tr0 = 1'b1;
         #1 chk("edge mode", st0, 32'(m >= 2));
         step(1);
         {tr0, en0} = 2'h0;
      end
      $display("edge modes done");
      // Let the low enable reach the design so the new run starts armed
      step(1);
      {use0, en0, en1, tick} = 4'h7;
      step(1);
      tick = 1'b0;
      step(20);
      tr0 = 1'b1;
      step(1);
      tr0 = 1'b0;
      acc(1'b0, 8'h4c, 32'h0);
      chk("time", q, 32'h3e8);
      acc(1'b0, 8'h4a, 32'h0);
      chk("flag", q, 32'h1);
      acc(1'b0, 8'h64, 32'h0);
      chk("chan1 flag", q, 32'h0);
      {tr0, tr1} = 2'h3;
      #1 chk("single shot", st0, 32'h0);
      chk("chan1 strobe", st1, 32'h1);
      step(1);
      {tr0, tr1, en0} = 3'h0;
      acc(1'b0, 8'h4a, 32'h0);
      chk("disabled flag", q, 32'h0);
      acc(1'b0, 8'h66, 32'h0);
      chk("chan1 time", q, 32'h546);
      en0 = 1'b1;
      acc(1'b0, 8'h4a, 32'h0);
      chk("rearmed flag", q, 32'h0);
      // Without time capture a new capture must leave the stored time alone
      kind0 = 1'b0;
      tr0 = 1'b1;
      step(1);
      tr0 = 1'b0;
      acc(1'b0, 8'h4a, 32'h0);
      chk("flag after rearm", q, 32'h1);
      acc(1'b0, 8'h4c, 32'h0);
      chk("time kept", q, 32'h3e8);
      $display("capture done");
      rst = 1'b1;
      step(10);
      rst = 1'b0;
      acc(1'b0, 8'h62, 32'h0);
      chk("selector reset", q, 32'h0);
      chk("sync idle", lost, 32'h0);
      step(2400);
      chk("sync kept", lost, 32'h0);
      step(200);
      chk("sync lost", lost, 32'h1);
      $display("second reset done");
      stop_test();
   end
endmodule
bind pcpt_capture_top pcpt_capture_chk i_pcpt_capture_chk (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_ack(reg_ack), .reg_err(reg_err), .chan0_capture_enable(chan0_capture_enable),
   .chan0_trigger_event(chan0_trigger_event), .chan0_capture_strobe(chan0_capture_strobe),
   .chan0_precondition_source(chan0_precondition_source),
   .chan1_capture_enable(chan1_capture_enable), .chan1_trigger_event(chan1_trigger_event),
   .chan1_capture_strobe(chan1_capture_strobe),
   .chan1_precondition_source(chan1_precondition_source));

// ---- tb/pcpt_host_model.sv ----
// Fieldbus host model issuing single register requests
`timescale 1ns/1ps
module pcpt_host_model (
   input logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [31:0] reg_wdata,
   input logic [31:0] reg_rdata,
   input logic reg_ack,
   input logic reg_err
);
   initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 42'h0;
   // Requests last one cycle; the ack is registered and settled just after that edge
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e, output logic ok);
      @(posedge clk);
      #1;
      {reg_addr, reg_wr, reg_rd, reg_wdata} = {a, w, !w, d};
      @(posedge clk);
      #1;
      // Idle lines carry inverted values so a stale sample cannot pass
      {reg_addr, reg_wr, reg_rd, reg_wdata} = {~a, 2'h0, ~d};
      ok = reg_ack;
      q = reg_rdata;
      e = reg_err;
   endtask
endmodule
